// ==== design/lbc_exec.sv ====
// Decode and execute of nibble/byte AND, carry-bit AND and bit clear
// Function
// - AND result bit is one only when both operand bits are one.
// - Result goes to destination; source operand keeps its contents.
// - Accumulator AND immediate is two bytes, two cycles, data in low nibble.
// - Accumulator AND pointer-pair memory is one byte, one cycle.
// - Pair into extended accumulator: two bytes, bit 3 set, r2 r1 select.
// - Extended accumulator into pair: same first byte, bit 3 clear.
// - Carry bit AND clears carry on zero bit, keeps it on one.
// - Carry bit AND never modifies the source bit.
// - Every carry bit AND form is two bytes and two cycles.
// - Indexed address is six one bits, four encoded bits, then L bits 3-2; L 1-0 bit.
// - Pointer plus direct uses H high nibble, direct low nibble.
// - Bit clear zeroes only the addressed bit.
// - Bit clear has four addressing forms, each two bytes, two cycles.
// - Pointer plus direct bit clear always acts on bank 0.
`timescale 1ns/1ps
module lbc_exec (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic IR_VALID,
    input wire logic [7:0] IR_BYTE,
    output logic IR_TAKEN,
    input wire logic [3:0] A_IN,
    input wire logic [7:0] EA_IN,
    input wire logic [3:0] H_IN,
    input wire logic [3:0] L_IN,
    input wire logic [7:0] PAIR_RD,
    input wire logic [3:0] MEM_RD_DATA,
    input wire logic C_IN,
    input wire logic BANK_EN,
    input wire logic [3:0] BANK_SEL,
    output logic [11:0] MEM_ADDR,
    output logic MEM_RE,
    output logic [1:0] PAIR_SEL,
    output logic ACC_WE,
    output logic [3:0] ACC_WR,
    output logic EA_WE,
    output logic [7:0] EA_WR,
    output logic PAIR_WE,
    output logic [1:0] PAIR_WSEL,
    output logic [7:0] PAIR_WR,
    output logic C_WE,
    output logic C_WR,
    output logic MEM_WE,
    output logic [11:0] MEM_WADDR,
    output logic [3:0] MEM_WR,
    output logic DONE
);
    // ----------------------------------------
    // First byte classification
    // ----------------------------------------
    function automatic lbc_pkg::lbc_kind_t kind_of(input logic [7:0] b);
        if ((b & lbc_pkg::BIT_CLEAR_DIR_MASK) == lbc_pkg::BIT_CLEAR_DIR_CODE) begin
            kind_of = lbc_pkg::K_BIT_CLEAR_DIR;
        end else begin
            // AND, carry AND and bit clear first bytes
            unique case (b)
                lbc_pkg::OPC_AND_IMM: kind_of = lbc_pkg::K_AND_IMM;
                lbc_pkg::OPC_AND_MEM: kind_of = lbc_pkg::K_AND_MEM;
                lbc_pkg::OPC_AND_PAIR: kind_of = lbc_pkg::K_AND_PAIR;
                lbc_pkg::OPC_BAND: kind_of = lbc_pkg::K_BAND;
                lbc_pkg::OPC_BIT_CLEAR: kind_of = lbc_pkg::K_BIT_CLEAR;
                default: kind_of = lbc_pkg::K_NONE;
            endcase
        end
    endfunction

    // second byte selects bit addressing form
    function automatic lbc_pkg::lbc_amode_t mode_of(input logic [7:0] b);
        if (b[lbc_pkg::HIGH_IO_POS]) begin
            mode_of = lbc_pkg::AM_HIGH_IO;
        end else if (b[7:4] == lbc_pkg::INDEXED_HI) begin
            mode_of = lbc_pkg::AM_INDEXED;
        end else begin
            mode_of = lbc_pkg::AM_PTR_DIRECT;
        end
    endfunction

    lbc_pkg::lbc_state_t state, next_state;
    lbc_pkg::lbc_kind_t kind, next_kind;
    logic [7:0] first, next_first;
    lbc_pkg::lbc_op_t ex_op, next_ex_op;
    logic [11:0] next_mem_addr;
    logic [1:0] ex_bit, next_ex_bit;
    logic [3:0] ex_imm, next_ex_imm;
    logic [1:0] next_pair_sel;
    logic next_mem_re;
    logic bad_form;

    lbc_addr_if ai ();

    lbc_bit_addr u_addr (
        .af(ai.former)
    );

    assign ai.byte1 = first;
    assign ai.byte2 = IR_BYTE;
    assign ai.h = H_IN;
    assign ai.l = L_IN;
    assign ai.bank_en = BANK_EN;
    assign ai.bank_sel = BANK_SEL;
    assign ai.mode = (state == lbc_pkg::ST_FIRST) ? lbc_pkg::AM_POINTER
                   : (kind == lbc_pkg::K_BIT_CLEAR_DIR) ? lbc_pkg::AM_DIRECT
                   : mode_of(IR_BYTE);
    assign bad_form = (IR_BYTE[7:6] == 2'h1) && (IR_BYTE[7:4] != lbc_pkg::INDEXED_HI);
    assign IR_TAKEN = IR_VALID &&
                      ((state == lbc_pkg::ST_SECOND) || (kind_of(IR_BYTE) != lbc_pkg::K_NONE));

    // ----------------------------------------
    // Decode stage
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_kind = kind;
        next_first = first;
        next_ex_op = lbc_pkg::OP_NONE;
        next_mem_addr = MEM_ADDR;
        next_ex_bit = ex_bit;
        next_ex_imm = ex_imm;
        next_pair_sel = PAIR_SEL;
        next_mem_re = 1'b0;
        if (IR_VALID) begin
            unique case (state)
                lbc_pkg::ST_FIRST: begin
                    next_first = IR_BYTE;
                    next_kind = kind_of(IR_BYTE);
                    if (kind_of(IR_BYTE) == lbc_pkg::K_AND_MEM) begin
                        next_ex_op = lbc_pkg::OP_AND_MEM;
                        next_mem_addr = ai.addr;
                        next_mem_re = 1'b1;
                    end else if (kind_of(IR_BYTE) != lbc_pkg::K_NONE) begin
                        next_state = lbc_pkg::ST_SECOND;
                    end
                end
                lbc_pkg::ST_SECOND: begin
                    // second byte completes every two-byte form
                    next_state = lbc_pkg::ST_FIRST;
                    next_mem_addr = ai.addr;
                    next_ex_bit = ai.bit_no;
                    unique case (kind)
                        lbc_pkg::K_AND_IMM: begin
                            next_ex_imm = IR_BYTE[3:0];
                            if (IR_BYTE[7:4] == lbc_pkg::AND_SECOND_HI) begin
                                next_ex_op = lbc_pkg::OP_AND_IMM;
                            end
                        end
                        // bit 3 set, bit 3 clear
                        lbc_pkg::K_AND_PAIR: begin
                            next_pair_sel = IR_BYTE[2:1];
                            if (IR_BYTE[7:4] == lbc_pkg::AND_SECOND_HI && !IR_BYTE[0]) begin
                                next_ex_op = IR_BYTE[lbc_pkg::PAIR_DIR_POS]
                                           ? lbc_pkg::OP_AND_EA_PAIR
                                           : lbc_pkg::OP_AND_PAIR_EA;
                            end
                        end
                        lbc_pkg::K_BAND: begin
                            next_mem_re = !bad_form;
                            next_ex_op = bad_form ? lbc_pkg::OP_NONE : lbc_pkg::OP_BAND;
                        end
                        lbc_pkg::K_BIT_CLEAR: begin
                            next_mem_re = !bad_form;
                            next_ex_op = bad_form ? lbc_pkg::OP_NONE : lbc_pkg::OP_BIT_CLEAR;
                        end
                        lbc_pkg::K_BIT_CLEAR_DIR: begin
                            next_mem_re = 1'b1;
                            next_ex_op = lbc_pkg::OP_BIT_CLEAR;
                        end
                        default: next_ex_op = lbc_pkg::OP_NONE;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= lbc_pkg::ST_FIRST;
            kind <= lbc_pkg::K_NONE;
            first <= 8'h00;
            ex_op <= lbc_pkg::OP_NONE;
            MEM_ADDR <= 12'h000;
            ex_bit <= 2'h0;
            ex_imm <= 4'h0;
            PAIR_SEL <= 2'h0;
            MEM_RE <= 1'b0;
        end else if (CE) begin
            state <= next_state;
            kind <= next_kind;
            first <= next_first;
            ex_op <= next_ex_op;
            MEM_ADDR <= next_mem_addr;
            ex_bit <= next_ex_bit;
            ex_imm <= next_ex_imm;
            PAIR_SEL <= next_pair_sel;
            MEM_RE <= next_mem_re;
        end
    end

    // ----------------------------------------
    // Execute and write-back stage
    // ----------------------------------------
    // Reads come back in the execute cycle; writes land one cycle later, so the
    // core must not issue a dependent read in that gap.
    logic next_acc_we, next_ea_we, next_pair_we, next_c_we, next_c_wr, next_mem_we;
    logic [3:0] next_acc_wr, next_mem_wr;
    logic [7:0] next_ea_wr, next_pair_wr;

    always_comb begin
        next_acc_we = 1'b0;
        next_acc_wr = ACC_WR;
        next_ea_we = 1'b0;
        next_ea_wr = EA_WR;
        next_pair_we = 1'b0;
        next_pair_wr = PAIR_WR;
        next_c_we = 1'b0;
        next_c_wr = C_WR;
        next_mem_we = 1'b0;
        next_mem_wr = MEM_WR;
        unique case (ex_op)
            lbc_pkg::OP_NONE: next_acc_we = 1'b0;
            lbc_pkg::OP_AND_IMM: begin
                next_acc_we = 1'b1;
                next_acc_wr = A_IN & ex_imm;
            end
            lbc_pkg::OP_AND_MEM: begin
                next_acc_we = 1'b1;
                next_acc_wr = A_IN & MEM_RD_DATA;
            end
            lbc_pkg::OP_AND_EA_PAIR: begin
                next_ea_we = 1'b1;
                next_ea_wr = EA_IN & PAIR_RD;
            end
            lbc_pkg::OP_AND_PAIR_EA: begin
                next_pair_we = 1'b1;
                next_pair_wr = PAIR_RD & EA_IN;
            end
            // clear on zero, no memory write
            lbc_pkg::OP_BAND: begin
                next_c_we = !MEM_RD_DATA[ex_bit];
                next_c_wr = C_IN & MEM_RD_DATA[ex_bit];
            end
            lbc_pkg::OP_BIT_CLEAR: begin
                next_mem_we = 1'b1;
                next_mem_wr = MEM_RD_DATA & ~(lbc_pkg::BIT_ONE << ex_bit);
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ACC_WE <= 1'b0;
            ACC_WR <= 4'h0;
            EA_WE <= 1'b0;
            EA_WR <= 8'h00;
            PAIR_WE <= 1'b0;
            PAIR_WSEL <= 2'h0;
            PAIR_WR <= 8'h00;
            C_WE <= 1'b0;
            C_WR <= 1'b0;
            MEM_WE <= 1'b0;
            MEM_WADDR <= 12'h000;
            MEM_WR <= 4'h0;
            DONE <= 1'b0;
        end else if (CE) begin
            ACC_WE <= next_acc_we;
            ACC_WR <= next_acc_wr;
            EA_WE <= next_ea_we;
            EA_WR <= next_ea_wr;
            PAIR_WE <= next_pair_we;
            PAIR_WSEL <= PAIR_SEL;
            PAIR_WR <= next_pair_wr;
            C_WE <= next_c_we;
            C_WR <= next_c_wr;
            MEM_WE <= next_mem_we;
            MEM_WADDR <= MEM_ADDR;
            MEM_WR <= next_mem_wr;
            DONE <= (ex_op != lbc_pkg::OP_NONE);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_and_imm_value: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && ex_op == lbc_pkg::OP_AND_IMM) |=> ACC_WE && ACC_WR == ($past(A_IN) & $past(ex_imm)))
        else $error("immediate AND result wrong");
    chk_mem_one_cycle: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && IR_VALID && state == lbc_pkg::ST_FIRST && IR_BYTE == lbc_pkg::OPC_AND_MEM)
        |=> ex_op == lbc_pkg::OP_AND_MEM && MEM_RE && state == lbc_pkg::ST_FIRST)
        else $error("indirect AND not one cycle");
    chk_pair_source_kept: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && ex_op == lbc_pkg::OP_AND_EA_PAIR) |=> EA_WE && !PAIR_WE && !ACC_WE)
        else $error("source pair written");
    chk_band_clears: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && ex_op == lbc_pkg::OP_BAND && !MEM_RD_DATA[ex_bit]) |=> C_WE && !C_WR)
        else $error("carry not cleared");
    chk_band_keeps: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && ex_op == lbc_pkg::OP_BAND && MEM_RD_DATA[ex_bit]) |=> !C_WE && !MEM_WE)
        else $error("carry or source disturbed");
    chk_bit_clear_one_bit: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && ex_op == lbc_pkg::OP_BIT_CLEAR) |=> MEM_WE && MEM_WADDR == $past(MEM_ADDR)
        && (MEM_WR ^ $past(MEM_RD_DATA)) == ($past(MEM_RD_DATA) & (4'h1 << $past(ex_bit))))
        else $error("bit clear touched other bits");
    chk_two_byte_wait: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && IR_TAKEN && state == lbc_pkg::ST_FIRST && IR_BYTE == lbc_pkg::OPC_BIT_CLEAR)
        |=> state == lbc_pkg::ST_SECOND && ex_op == lbc_pkg::OP_NONE)
        else $error("two-byte form finished early");
    chk_indexed_addr: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && IR_VALID && state == lbc_pkg::ST_SECOND && kind == lbc_pkg::K_BAND
        && IR_BYTE[7:4] == 4'h4) |=> MEM_ADDR == {6'h3f, $past(IR_BYTE[3:0]), $past(L_IN[3:2])}
        && ex_bit == $past(L_IN[1:0]))
        else $error("indexed address wrong");
    chk_ptr_bank_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (CE && IR_VALID && state == lbc_pkg::ST_SECOND && kind == lbc_pkg::K_BIT_CLEAR
        && IR_BYTE[7:6] == 2'h0) |=> MEM_ADDR == {4'h0, $past(H_IN), $past(IR_BYTE[3:0])})
        else $error("pointer plus direct not bank 0");
endmodule

// ==== pkg/lbc_pkg.sv ====
// Constants and types for the logic-AND and bit-clear execute block
package lbc_pkg;
    // ----------------------------------------
    // First opcode bytes
    // ----------------------------------------
    localparam logic [7:0] OPC_AND_IMM = 8'hdd;
    localparam logic [7:0] OPC_AND_MEM = 8'h39;
    localparam logic [7:0] OPC_AND_PAIR = 8'hdc;
    localparam logic [7:0] OPC_BAND = 8'hf5;
    localparam logic [7:0] OPC_BIT_CLEAR = 8'hfe;
    localparam logic [7:0] BIT_CLEAR_DIR_MASK = 8'hcf;
    localparam logic [7:0] BIT_CLEAR_DIR_CODE = 8'hc0;
    // ----------------------------------------
    // Second byte fields
    // ----------------------------------------
    localparam logic [3:0] AND_SECOND_HI = 4'h1;
    localparam int PAIR_DIR_POS = 3;
    localparam logic [3:0] INDEXED_HI = 4'h4;
    localparam logic [1:0] PTR_DIRECT_HI = 2'h0;
    localparam int HIGH_IO_POS = 7;
    localparam int HIGH_IO_PAGE_POS = 6;
    // ----------------------------------------
    // Address formation
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [3:0] PAGE_LOW = 4'h0;
    localparam logic [3:0] PAGE_HIGH = 4'hf;
    localparam logic [3:0] HIGH_IO_FB = 4'hb;
    localparam logic [3:0] HIGH_IO_FF = 4'hf;
    localparam logic [1:0] INDEXED_TOP = 2'h3;
    localparam logic [3:0] BIT_ONE = 4'h1;

    typedef enum logic [2:0] {
        AM_DIRECT, AM_HIGH_IO, AM_INDEXED, AM_PTR_DIRECT, AM_POINTER
    } lbc_amode_t;

    typedef enum logic [2:0] {
        K_NONE, K_AND_IMM, K_AND_MEM, K_AND_PAIR, K_BAND, K_BIT_CLEAR_DIR, K_BIT_CLEAR
    } lbc_kind_t;

    typedef enum logic [2:0] {
        OP_NONE, OP_AND_IMM, OP_AND_MEM, OP_AND_EA_PAIR, OP_AND_PAIR_EA, OP_BAND, OP_BIT_CLEAR
    } lbc_op_t;

    typedef enum logic {ST_FIRST, ST_SECOND} lbc_state_t;
endpackage

// ==== pkg/lbc_addr_if.sv ====
// Bit-address request and answer between decoder and address former
`timescale 1ns/1ps
interface lbc_addr_if;
    lbc_pkg::lbc_amode_t mode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [3:0] h;
    logic [3:0] l;
    logic bank_en;
    logic [3:0] bank_sel;
    logic [11:0] addr;
    logic [1:0] bit_no;

    modport user (output mode, byte1, byte2, h, l, bank_en, bank_sel, input addr, bit_no);
    modport former (input mode, byte1, byte2, h, l, bank_en, bank_sel, output addr, bit_no);
endinterface

// ==== design/lbc_bit_addr.sv ====
// Nibble address and bit number former for all operand forms
`timescale 1ns/1ps
module lbc_bit_addr (
    lbc_addr_if.former af
);
    // ----------------------------------------
    // Bank mapping
    // ----------------------------------------
    function automatic logic [11:0] banked(input logic en, input logic [3:0] sel,
                                           input logic [7:0] a);
        if (en) begin
            banked = {sel, a};
        end else begin
            // Without banking, the upper half maps onto the I/O page
            banked = {(a[7] ? lbc_pkg::PAGE_HIGH : lbc_pkg::PAGE_LOW), a};
        end
    endfunction

    always_comb begin
        af.addr = '0;
        af.bit_no = '0;
        unique case (af.mode)
            lbc_pkg::AM_DIRECT: begin
                af.addr = banked(af.bank_en, af.bank_sel, af.byte2);
                af.bit_no = af.byte1[5:4];
            end
            lbc_pkg::AM_HIGH_IO: begin
                af.addr = {lbc_pkg::PAGE_HIGH,
                           (af.byte2[lbc_pkg::HIGH_IO_PAGE_POS] ? lbc_pkg::HIGH_IO_FF
                                                                 : lbc_pkg::HIGH_IO_FB),
                           af.byte2[3:0]};
                af.bit_no = af.byte2[5:4];
            end
            lbc_pkg::AM_INDEXED: begin
                af.addr = {lbc_pkg::PAGE_HIGH, lbc_pkg::INDEXED_TOP, af.byte2[3:0], af.l[3:2]};
                af.bit_no = af.l[1:0];
            end
            // H plus direct, always bank 0
            lbc_pkg::AM_PTR_DIRECT: begin
                af.addr = {lbc_pkg::PAGE_LOW, af.h, af.byte2[3:0]};
                af.bit_no = af.byte2[5:4];
            end
            lbc_pkg::AM_POINTER: begin
                af.addr = banked(af.bank_en, af.bank_sel, {af.h, af.l});
                af.bit_no = '0;
            end
            default: begin
                af.addr = '0;
                af.bit_no = '0;
            end
        endcase
    end
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the logic-AND and bit-clear execute block
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // Stimulus and expectation rows
    // ----------------------------------------
    typedef struct {
        logic [7:0] b1, b2;
        logic two;
        logic [3:0] h, l, mem;
        logic be;
        logic [3:0] bs;
        logic re;
        logic [11:0] addr;
        logic [2:0] wk;
        logic [11:0] waddr;
        logic [7:0] wv;
    } lbc_row_t;

    logic REF_CLK = 1'b0, RST_B = 1'b0, CE = 1'b1, IR_VALID = 1'b0, C_IN = 1'b1;
    logic BANK_EN = 1'b0, IR_TAKEN, MEM_RE, ACC_WE, EA_WE, PAIR_WE, C_WE, C_WR, MEM_WE, DONE;
    logic [7:0] IR_BYTE = 8'h00, EA_IN = 8'hc3, PAIR_RD = 8'h55, EA_WR, PAIR_WR;
    logic [3:0] A_IN = 4'hb, H_IN = 4'h0, L_IN = 4'h0, MEM_RD_DATA = 4'h0, BANK_SEL = 4'h0;
    logic [3:0] ACC_WR, MEM_WR;
    logic [11:0] MEM_ADDR, MEM_WADDR;
    logic [1:0] PAIR_SEL, PAIR_WSEL;
    int failures = 0, check_count = 0, cycles = 0;
    lbc_row_t rows [16];

    lbc_exec dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .CE(CE), .IR_VALID(IR_VALID),
        .IR_BYTE(IR_BYTE), .IR_TAKEN(IR_TAKEN), .A_IN(A_IN), .EA_IN(EA_IN), .H_IN(H_IN),
        .L_IN(L_IN), .PAIR_RD(PAIR_RD), .MEM_RD_DATA(MEM_RD_DATA), .C_IN(C_IN),
        .BANK_EN(BANK_EN), .BANK_SEL(BANK_SEL), .MEM_ADDR(MEM_ADDR), .MEM_RE(MEM_RE),
        .PAIR_SEL(PAIR_SEL), .ACC_WE(ACC_WE), .ACC_WR(ACC_WR), .EA_WE(EA_WE), .EA_WR(EA_WR),
        .PAIR_WE(PAIR_WE), .PAIR_WSEL(PAIR_WSEL), .PAIR_WR(PAIR_WR), .C_WE(C_WE),
        .C_WR(C_WR), .MEM_WE(MEM_WE), .MEM_WADDR(MEM_WADDR), .MEM_WR(MEM_WR), .DONE(DONE));

    always #5 REF_CLK = ~REF_CLK;

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check_bit(input logic act, input logic exp);
        check_count++;
        if (act !== exp) begin
            failures++;
            $display("FAIL %0t flag got %b want %b", $time, act, exp);
        end
    endtask

    task automatic check_vec(input logic [11:0] act, input logic [11:0] exp);
        check_count++;
        if (act !== exp) begin
            failures++;
            $display("FAIL %0t value got %h want %h", $time, act, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Generous ceiling; the whole run needs about a hundred cycles
    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            finish_test();
        end
    end

    // ----------------------------------------
    // One instruction, optional gap between bytes
    // ----------------------------------------
    task automatic run_row(input lbc_row_t r, input int gap);
        @(posedge REF_CLK);
        H_IN <= r.h;
        L_IN <= r.l;
        MEM_RD_DATA <= r.mem;
        BANK_EN <= r.be;
        BANK_SEL <= r.bs;
        IR_BYTE <= r.b1;
        IR_VALID <= 1'b1;
        @(negedge REF_CLK);
        check_bit(IR_TAKEN, 1'b1);
        if (r.two) begin
            repeat (gap) begin
                @(posedge REF_CLK);
                IR_VALID <= 1'b0;
            end
            @(posedge REF_CLK);
            IR_VALID <= 1'b1;
            IR_BYTE <= r.b2;
            @(negedge REF_CLK);
            check_bit(IR_TAKEN, 1'b1);
        end
        @(posedge REF_CLK);
        IR_VALID <= 1'b0;
        @(negedge REF_CLK);
        check_bit(MEM_RE, r.re);
        if (r.re) check_vec(MEM_ADDR, r.addr);
        if (r.wk == 3'h2 || r.wk == 3'h3) check_vec({10'h0, PAIR_SEL}, r.waddr);
        @(negedge REF_CLK);
        check_bit(DONE, 1'b1);
        check_bit(ACC_WE, r.wk == 3'h1);
        check_bit(EA_WE, r.wk == 3'h2);
        check_bit(PAIR_WE, r.wk == 3'h3);
        check_bit(C_WE, r.wk == 3'h4);
        check_bit(MEM_WE, r.wk == 3'h5);
        if (r.wk == 3'h1) check_vec({8'h0, ACC_WR}, {8'h0, r.wv[3:0]});
        if (r.wk == 3'h2) check_vec({4'h0, EA_WR}, {4'h0, r.wv});
        if (r.wk == 3'h3) check_vec({4'h0, PAIR_WR}, {4'h0, r.wv});
        if (r.wk == 3'h3) check_vec({10'h0, PAIR_WSEL}, r.waddr);
        if (r.wk == 3'h4) check_bit(C_WR, 1'b0);
        if (r.wk == 3'h5) check_vec(MEM_WADDR, r.waddr);
        if (r.wk == 3'h5) check_vec({8'h0, MEM_WR}, {8'h0, r.wv[3:0]});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rows[0] = '{8'hdd, 8'h16, 1, 4'h0, 4'h0, 4'h0, 0, 4'h0, 0, 12'h000, 3'h1, 12'h000, 8'h02};
        rows[1] = '{8'h39, 8'h00, 0, 4'h3, 4'h4, 4'he, 0, 4'h0, 1, 12'h034, 3'h1, 12'h000, 8'h0a};
        rows[2] = '{8'hdc, 8'h1c, 1, 4'h0, 4'h0, 4'h0, 0, 4'h0, 0, 12'h000, 3'h2, 12'h002, 8'h41};
        rows[3] = '{8'hdc, 8'h12, 1, 4'h0, 4'h0, 4'h0, 0, 4'h0, 0, 12'h000, 3'h3, 12'h001, 8'h41};
        // carry-bit forms, bit zero and bit one
        rows[4] = '{8'hf5, 8'h25, 1, 4'h3, 4'h0, 4'hb, 0, 4'h0, 1, 12'h035, 3'h4, 12'h000, 8'h00};
        rows[5] = '{8'hf5, 8'h25, 1, 4'h3, 4'h0, 4'h4, 0, 4'h0, 1, 12'h035, 3'h0, 12'h000, 8'h00};
        rows[6] = '{8'hf5, 8'h4c, 1, 4'h0, 4'h5, 4'hd, 0, 4'h0, 1, 12'hff1, 3'h4, 12'h000, 8'h00};
        rows[7] = '{8'hf5, 8'hb3, 1, 4'h0, 4'h0, 4'h7, 0, 4'h0, 1, 12'hfb3, 3'h4, 12'h000, 8'h00};
        rows[8] = '{8'hf5, 8'he1, 1, 4'h0, 4'h0, 4'hb, 0, 4'h0, 1, 12'hff1, 3'h4, 12'h000, 8'h00};
        // bit clear, direct pages and banked
        rows[9] = '{8'he0, 8'h30, 1, 4'h0, 4'h0, 4'hf, 0, 4'h0, 1, 12'h030, 3'h5, 12'h030, 8'h0b};
        rows[10] = '{8'hd0, 8'h8a, 1, 4'h0, 4'h0, 4'hf, 1, 4'h2, 1, 12'h28a, 3'h5, 12'h28a, 8'h0d};
        rows[11] = '{8'hc0, 8'h85, 1, 4'h0, 4'h0, 4'hf, 0, 4'h0, 1, 12'hf85, 3'h5, 12'hf85, 8'h0e};
        // bit clear, other forms; banked pointer form stays in bank 0
        rows[12] = '{8'hfe, 8'hbe, 1, 4'h0, 4'h0, 4'hf, 0, 4'h0, 1, 12'hfbe, 3'h5, 12'hfbe, 8'h07};
        rows[13] = '{8'hfe, 8'hc5, 1, 4'h0, 4'h0, 4'h3, 0, 4'h0, 1, 12'hff5, 3'h5, 12'hff5, 8'h02};
        rows[14] = '{8'hfe, 8'h4c, 1, 4'h0, 4'ha, 4'hf, 0, 4'h0, 1, 12'hff2, 3'h5, 12'hff2, 8'h0b};
        rows[15] = '{8'hfe, 8'h25, 1, 4'ha, 4'h0, 4'h4, 1, 4'h5, 1, 12'h0a5, 3'h5, 12'h0a5, 8'h00};
        repeat (10) @(posedge REF_CLK);
        check_bit(DONE, 1'b0);
        check_vec(MEM_ADDR, 12'h000);
        repeat (6) @(posedge REF_CLK);
        RST_B <= 1'b1;
        foreach (rows[i]) run_row(rows[i], 0);
        // gap between opcode and second byte
        run_row(rows[15], 2);
        // byte outside the group is refused
        @(posedge REF_CLK);
        IR_BYTE <= 8'ha5;
        IR_VALID <= 1'b1;
        @(negedge REF_CLK);
        check_bit(IR_TAKEN, 1'b0);
        // malformed immediate byte leaves no effect
        @(posedge REF_CLK);
        IR_BYTE <= 8'hdd;
        @(posedge REF_CLK);
        IR_BYTE <= 8'h26;
        @(posedge REF_CLK);
        IR_VALID <= 1'b0;
        repeat (3) begin
            @(negedge REF_CLK);
            check_bit(DONE | ACC_WE, 1'b0);
        end
        // Clock enable low freezes the pipeline; write-back waits for it
        @(posedge REF_CLK);
        IR_BYTE <= 8'h39;
        IR_VALID <= 1'b1;
        MEM_RD_DATA <= 4'h6;
        @(posedge REF_CLK);
        IR_VALID <= 1'b0;
        CE <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        @(negedge REF_CLK);
        check_bit(ACC_WE, 1'b0);
        check_bit(MEM_RE, 1'b1);
        @(posedge REF_CLK);
        CE <= 1'b1;
        @(posedge REF_CLK);
        @(negedge REF_CLK);
        check_bit(ACC_WE, 1'b1);
        check_vec({8'h0, ACC_WR}, 12'h002);
        // Reset in mid-instruction drops the pending opcode byte
        @(posedge REF_CLK);
        IR_BYTE <= 8'hfe;
        IR_VALID <= 1'b1;
        @(posedge REF_CLK);
        IR_VALID <= 1'b0;
        RST_B <= 1'b0;
        @(negedge REF_CLK);
        check_bit(DONE, 1'b0);
        check_vec(MEM_ADDR, 12'h000);
        @(posedge REF_CLK);
        RST_B <= 1'b1;
        IR_BYTE <= 8'h25;
        IR_VALID <= 1'b1;
        @(negedge REF_CLK);
        check_bit(IR_TAKEN, 1'b0);
        @(posedge REF_CLK);
        IR_VALID <= 1'b0;
        run_row(rows[0], 0);
        finish_test();
    end
endmodule
